// ---- rtl/fbp_port.sv ----
// Four bit general purpose port with parallel strobe status bits.
// Operation
// - Four bit port, three pins with direction
// - Analog-selected pins read as zero
// - Direction one tri-states, zero drives latch
// - Direction still controls drivers in analog
// - Low pins analog while config input is below 0xA
// - Latch register reads latch, not pins
// - Reset enable zero: pin three input
// - Pin three fixed input, no latch
// - Reset enable set: pin three resets
// - Narrow variant: only pin three
// - In-full bit seven read only
// - Out-full bit six read only
// - Overflow bit five, software clear only
// - Bit four selects parallel mode
// - Unimplemented bits read zero
// - Drive from latch; analog zeroes pin reads, strobes still decode
// - Write end sets in-full and flag
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fbp_port #(
   parameter bit WIDE = 1'b1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [2:0] port4_pin_i,
   output logic [2:0] port4_pin_o,
   output logic [2:0] port4_pin_oe_o,
   input wire logic port4_pin3_input_only_i,
   input wire logic master_reset_pin_enable_i,
   input wire logic [3:0] analog_pin_config_field_i,
   input wire logic par_data_read_i,
   input wire logic par_data_written_i,
   output logic master_reset_req_o,
   output logic parallel_port_irq_flag_o
);
   typedef struct packed {
      logic [2:0] dir;
      logic [2:0] latch;
      logic in_full;
      logic out_full;
      logic in_ovf;
      logic par_mode;
      logic irq;
      logic [7:0] rdata;
      logic [2:0] pin_o;
      logic [2:0] pin_oe;
      logic mrst;
   } fbp_port_s;
   fbp_port_s q_r;
   fbp_port_s q_nxt;
   logic [3:0] pins_sync;
   logic wr_end;
   logic rd_start;
   logic analog_sel;
   logic [3:0] pin_view;
   fbp_sync_if sif ();

   // ==========================================================
   // Pin synchronisation.
   assign sif.raw = {port4_pin3_input_only_i, port4_pin_i};
   assign pins_sync = sif.synced;
   fbp_sync u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .s(sif.snk)
   );

   // ==========================================================
   // Parallel strobe decode on synchronised pins.
   fbp_edge u_edge (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(q_r.par_mode && WIDE),
      .rd_n_i(pins_sync[0]),
      .wr_n_i(pins_sync[1]),
      .cs_n_i(pins_sync[2]),
      .wr_end_o(wr_end),
      .rd_start_o(rd_start)
   );

   // ==========================================================
   // Analog selection: any config below the all-digital range.
   // Config is an input that this port never resets, so pins start analog only if it starts below the range.
   function automatic logic is_analog(input logic [3:0] cfg);
      return cfg < fbp_pkg::ANA_DIGITAL_MIN;
   endfunction

   // Pin value view seen by software.
   always_comb begin
      analog_sel = is_analog(analog_pin_config_field_i);
      pin_view = 4'h0;
      if (WIDE && !analog_sel) begin
         pin_view[2:0] = pins_sync[2:0];
      end
      if (!master_reset_pin_enable_i) begin
         pin_view[fbp_pkg::BIT_PIN3] = pins_sync[3];
      end
   end

   // ==========================================================
   // Next state: register writes, status flags and pin drivers.
   always_comb begin
      q_nxt = q_r;
      q_nxt.rdata = 8'h00;
      q_nxt.irq = 1'b0;
      if (reg_we_i) begin
         unique case (reg_addr_i)
            fbp_pkg::OFS_OUT_LATCH: q_nxt.latch = reg_wdata_i[2:0];
            fbp_pkg::OFS_DIR_STAT: begin
               q_nxt.dir = reg_wdata_i[2:0];
               q_nxt.par_mode = reg_wdata_i[fbp_pkg::BIT_PAR_MODE];
               // Overflow may only be cleared, never set, by software.
               if (!reg_wdata_i[fbp_pkg::BIT_IN_OVF]) begin
                  q_nxt.in_ovf = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // The parallel data path lives elsewhere; it reports its accesses.
      if (par_data_read_i) begin
         q_nxt.in_full = 1'b0;
      end
      // A new output word in the cycle of a read start keeps the flag set.
      if (rd_start) begin
         q_nxt.out_full = 1'b0;
      end
      if (par_data_written_i) begin
         q_nxt.out_full = 1'b1;
      end
      // Hardware set wins over any clear in the same cycle.
      if (wr_end) begin
         if (q_r.in_full) begin
            q_nxt.in_ovf = 1'b1;
         end
         q_nxt.in_full = 1'b1;
         q_nxt.irq = 1'b1;
      end
      if (reg_re_i) begin
         unique case (reg_addr_i)
            fbp_pkg::OFS_PIN_LEVEL: q_nxt.rdata = {4'h0, pin_view};
            fbp_pkg::OFS_OUT_LATCH: q_nxt.rdata = {5'h00, q_r.latch};
            fbp_pkg::OFS_DIR_STAT: q_nxt.rdata = {q_r.in_full, q_r.out_full,
               q_r.in_ovf, q_r.par_mode, 1'b0, q_r.dir};
            fbp_pkg::OFS_CONFIG: begin
               q_nxt.rdata[fbp_pkg::BIT_CFG_MRST_EN] = master_reset_pin_enable_i;
               q_nxt.rdata[fbp_pkg::BIT_CFG_WIDE] = WIDE;
               q_nxt.rdata[fbp_pkg::BIT_CFG_IRQ] = q_r.irq;
               q_nxt.rdata[3:0] = analog_pin_config_field_i;
            end
            default: ;
         endcase
      end
      // Direction drives the pin even in analog mode; only the narrow
      // variant has no drivers at all.
      q_nxt.pin_oe = WIDE ? ~q_nxt.dir : 3'h0;
      q_nxt.pin_o = WIDE ? q_nxt.latch : 3'h0;
      // Pin three never drives; it resets the core when so enabled.
      q_nxt.mrst = master_reset_pin_enable_i && !pins_sync[3];
   end

   // ==========================================================
   // State register.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_r <= '0;
         q_r.dir <= fbp_pkg::RST_DIR;
         q_r.latch <= fbp_pkg::RST_LATCH;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign reg_rdata_o = q_r.rdata;
   assign port4_pin_o = q_r.pin_o;
   assign port4_pin_oe_o = q_r.pin_oe;
   assign master_reset_req_o = q_r.mrst;
   assign parallel_port_irq_flag_o = q_r.irq;
endmodule
`default_nettype wire

// ---- rtl/fbp_pkg.sv ----
// Constants, register map and field layout of the four bit port.
`default_nettype none
package fbp_pkg;
   // ==========================================================
   // Register map, word index on the plain register port.
   localparam logic [1:0] OFS_PIN_LEVEL = 2'h0;
   localparam logic [1:0] OFS_OUT_LATCH = 2'h1;
   localparam logic [1:0] OFS_DIR_STAT = 2'h2;
   localparam logic [1:0] OFS_CONFIG = 2'h3;
   // ==========================================================
   // Field positions in the direction and status register, and pin three's bit in the pin level register.
   localparam int BIT_IN_FULL = 7;
   localparam int BIT_OUT_FULL = 6;
   localparam int BIT_IN_OVF = 5;
   localparam int BIT_PAR_MODE = 4;
   localparam int BIT_PIN3 = 3;
   // Field positions in the configuration register.
   localparam int BIT_CFG_MRST_EN = 7;
   localparam int BIT_CFG_WIDE = 6;
   localparam int BIT_CFG_IRQ = 5;
   // ==========================================================
   // Values after reset, analog threshold and synchroniser depth.
   localparam logic [2:0] RST_DIR = 3'h7;
   localparam logic [2:0] RST_LATCH = 3'h0;
   localparam logic [3:0] RST_ANA_CFG = 4'h0;
   localparam logic [3:0] ANA_DIGITAL_MIN = 4'hA;
   localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ---- rtl/fbp_sync_if.sv ----
// Interface carrying raw pin levels and their synchronised copies.
`timescale 1ns/1ps
`default_nettype none
interface fbp_sync_if;
   logic [3:0] raw;
   logic [3:0] synced;
   modport src (output raw, input synced);
   modport snk (input raw, output synced);
endinterface
`default_nettype wire

// ---- rtl/fbp_sync.sv ----
// Two stage synchroniser for the four port pins.
`timescale 1ns/1ps
`default_nettype none
module fbp_sync (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   fbp_sync_if.snk s
);
   typedef struct packed {
      logic [3:0] meta;
      logic [3:0] stab;
   } fbp_sync_s;
   fbp_sync_s q_r;
   fbp_sync_s q_nxt;
   // ==========================================================
   // The first stage feeds only the second stage.
   always_comb begin
      q_nxt.meta = s.raw;
      q_nxt.stab = q_r.meta;
   end
   // Reset to the idle level of the strobes and the reset pin, both
   // active low, so no false strobe or reset request follows reset.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_r <= '1;
      end else begin
         q_r <= q_nxt;
      end
   end
   assign s.synced = q_r.stab;
endmodule
`default_nettype wire

// ---- rtl/fbp_edge.sv ----
// Strobe qualifier: decodes parallel write and read phases.
`timescale 1ns/1ps
`default_nettype none
module fbp_edge (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic cs_n_i,
   output logic wr_end_o,
   output logic rd_start_o
);
   typedef struct packed {
      logic wr_act;
      logic rd_act;
   } fbp_edge_s;
   fbp_edge_s q_r;
   fbp_edge_s q_nxt;
   logic wr_low;
   logic rd_low;
   // ==========================================================
   // A write spans both strobes low; it ends when either rises.
   always_comb begin
      wr_low = enable_i && !cs_n_i && !wr_n_i;
      rd_low = enable_i && !cs_n_i && !rd_n_i;
      q_nxt.wr_act = wr_low;
      q_nxt.rd_act = rd_low;
      wr_end_o = q_r.wr_act && !wr_low;
      rd_start_o = rd_low && !q_r.rd_act;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- bench/fbp_port_checker.sv ----
// Timing checks on the four bit port's ports.
`timescale 1ns/1ps
`default_nettype none
module fbp_port_checker #(
   parameter bit WIDE = 1'b1
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [2:0] port4_pin_o,
   input wire logic [2:0] port4_pin_oe_o,
   input wire logic port4_pin3_input_only_i,
   input wire logic master_reset_pin_enable_i,
   input wire logic [3:0] analog_pin_config_field_i,
   input wire logic master_reset_req_o,
   input wire logic parallel_port_irq_flag_o
);
   // ========================================
   // Last write data, so pin checks can see it.
   logic [7:0] wd_r;
   always_ff @(posedge clk_i) wd_r <= reg_wdata_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire rd0 = reg_re_i && reg_addr_i == 2'h0;
   wire en = master_reset_pin_enable_i;
   a_dir_drives: assert property (
      WIDE && reg_we_i && reg_addr_i == 2'h2 |=>
      port4_pin_oe_o == ~wd_r[2:0]) else $error("oe wrong");
   a_latch_drives: assert property (
      WIDE && reg_we_i && reg_addr_i == 2'h1 |=>
      port4_pin_o == wd_r[2:0]) else $error("pin wrong");
   a_latch_reads: assert property (
      reg_re_i && reg_addr_i == 2'h1 |=>
      reg_rdata_o == {5'h00, port4_pin_o}) else $error("latch read");
   a_bit3_zero: assert property (
      reg_re_i && reg_addr_i == 2'h2 |=> !reg_rdata_o[3])
      else $error("bit3 set");
   a_analog_zero: assert property (
      rd0 && analog_pin_config_field_i < 4'hA &&
      $past(analog_pin_config_field_i, 4) < 4'hA |=>
      reg_rdata_o[2:0] == 3'h0) else $error("analog read");
   a_pin3_masked: assert property (
      rd0 && en |=> !reg_rdata_o[3]) else $error("pin3 read");
   a_mrst_on: assert property (
      (en && !port4_pin3_input_only_i)[*5] |-> master_reset_req_o)
      else $error("no reset");
   a_mrst_off: assert property (
      (!en)[*2] |-> !master_reset_req_o) else $error("false reset");
   a_irq_pulse: assert property (
      parallel_port_irq_flag_o |=> !parallel_port_irq_flag_o)
      else $error("irq long");
   c_irq: cover property (parallel_port_irq_flag_o);
   c_mrst: cover property (master_reset_req_o);
   c_ana: cover property (rd0 && analog_pin_config_field_i < 4'hA);
endmodule
bind fbp_port fbp_port_checker #(.WIDE(WIDE)) chk (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i),
   .reg_rdata_o(reg_rdata_o),
   .port4_pin_o(port4_pin_o),
   .port4_pin_oe_o(port4_pin_oe_o),
   .port4_pin3_input_only_i(port4_pin3_input_only_i),
   .master_reset_pin_enable_i(master_reset_pin_enable_i),
   .analog_pin_config_field_i(analog_pin_config_field_i),
   .master_reset_req_o(master_reset_req_o),
   .parallel_port_irq_flag_o(parallel_port_irq_flag_o)
);
`default_nettype wire

// ---- bench/fbp_pins_model.sv ----
// Far side: outside drivers and parallel strobes on the low pins.
`timescale 1ns/1ps
`default_nettype none
module fbp_pins_model (
   input wire logic clk_i,
   input wire logic [2:0] port4_pin_o,
   input wire logic [2:0] port4_pin_oe_o,
   input wire logic [2:0] ext_i,
   input wire logic psp_i,
   output logic [2:0] level_o
);
   logic [2:0] strb_r = 3'h7;
   // The port wins where it drives, else the outside level.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         level_o[i] = port4_pin_oe_o[i] ? port4_pin_o[i] :
            (psp_i ? strb_r[i] : ext_i[i]);
      end
   end
   // Select with write or read low for n cycles; idle all high.
   task automatic cycle(input bit wr, input int n);
      @(posedge clk_i);
      strb_r <= wr ? 3'h1 : 3'h2;
      repeat (n) @(posedge clk_i);
      strb_r <= 3'h7;
   endtask
endmodule
`default_nettype wire

// ---- bench/fbp_port_tb.sv ----
// Self-checking bench of the four bit port.
`timescale 1ns/1ps
`default_nettype none
module fbp_port_tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wd = 8'h00;
   logic [7:0] rd;
   logic [2:0] po, oe, lvl, ext = 3'h0;
   logic we = 1'b0, re = 1'b0, pin3 = 1'b1, en = 1'b0, parallel_slave_port = 1'b0;
   logic pdr = 1'b0, pdw = 1'b0, mrst, irq;
   logic [3:0] cfg = 4'h0;
   logic [31:0] seed = 32'h47;
   int n_fail = 0, checks = 0;
   // ========================================
   // Clock, design and far side.
   always #2.5 clk_i = ~clk_i;
   fbp_port dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd),
      .port4_pin_i(lvl), .port4_pin_o(po), .port4_pin_oe_o(oe),
      .port4_pin3_input_only_i(pin3), .master_reset_pin_enable_i(en),
      .analog_pin_config_field_i(cfg), .par_data_read_i(pdr),
      .par_data_written_i(pdw), .master_reset_req_o(mrst),
      .parallel_port_irq_flag_o(irq));
   fbp_pins_model pm (.clk_i(clk_i), .port4_pin_o(po),
      .port4_pin_oe_o(oe), .ext_i(ext), .psp_i(parallel_slave_port), .level_o(lvl));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected pin level read: analog hides low pins, reset use hides pin3.
   function automatic logic [7:0] pin_exp(input logic [2:0] l);
      return {4'h0, pin3 & !en, cfg < 4'hA ? 3'h0 : l};
   endfunction
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk_i);
      we <= 1'b0;
   endtask
   task automatic chk(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      re <= 1'b1;
      @(posedge clk_i);
      re <= 1'b0;
      @(negedge clk_i);
      cmp(rd, e);
   endtask
   task automatic wait_irq();
      int k;
      for (k = 0; k < 20 && irq !== 1'b1; k++) @(negedge clk_i);
      cmp({7'h00, irq}, 8'h01);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // The run needs some 300 cycles; the 4000 cycle limit means a hang.
   initial begin
      #20000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      logic [7:0] r, s;
      logic [2:0] lv;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(2'h2, 8'h07);
      chk(2'h0, pin_exp(3'h0));
      wr(2'h3, 8'hFF);
      chk(2'h3, 8'h40);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         s = rnd();
         @(posedge clk_i);
         ext <= r[7:5];
         pin3 <= r[3];
         cfg <= s[7:4];
         wr(2'h1, r);
         wr(2'h2, s & 8'hEF);
         wr(2'h0, ~r);
         repeat (5) @(posedge clk_i);
         lv = (r[2:0] & ~s[2:0]) | (r[7:5] & s[2:0]);
         @(negedge clk_i);
         cmp({5'h00, oe}, {5'h00, ~s[2:0]});
         cmp({5'h00, po}, r & 8'h07);
         chk(2'h1, r & 8'h07);
         chk(2'h2, s & 8'h07);
         chk(2'h0, pin_exp(lv));
      end
      $display("test pins done");
      @(posedge clk_i);
      en <= 1'b1;
      pin3 <= 1'b0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      cmp({7'h00, mrst}, 8'h01);
      chk(2'h0, pin_exp(lv));
      $display("test reset pin done");
      // Pins become inputs and settle before the strobes are decoded.
      @(posedge clk_i);
      en <= 1'b0;
      parallel_slave_port <= 1'b1;
      cfg <= 4'hF;
      wr(2'h2, 8'h07);
      repeat (4) @(posedge clk_i);
      wr(2'h2, 8'h17);
      pm.cycle(1'b1, 6);
      wait_irq();
      chk(2'h2, 8'h97);
      pm.cycle(1'b1, 6);
      wait_irq();
      chk(2'h2, 8'hB7);
      wr(2'h2, 8'hF7);
      chk(2'h2, 8'hB7);
      @(posedge clk_i) pdr <= 1'b1;
      @(posedge clk_i) pdr <= 1'b0;
      wr(2'h2, 8'h17);
      chk(2'h2, 8'h17);
      @(posedge clk_i) pdw <= 1'b1;
      @(posedge clk_i) pdw <= 1'b0;
      chk(2'h2, 8'h57);
      pm.cycle(1'b0, 6);
      repeat (6) @(posedge clk_i);
      chk(2'h2, 8'h17);
      $display("test parallel done");
      report_and_stop();
   end
endmodule
`default_nettype wire
